/* svw_defines.svh */
// Timing constants and encodings for the supervisor watchdog reset block
`ifndef SVW_DEFINES_SVH
`define SVW_DEFINES_SVH
`define SVW_CLK_PERIOD_NS     4
`define SVW_RELEASE_MS        200
`define SVW_RELEASE_PIN_MS    250
`define SVW_WD_LONG_MS        1400
`define SVW_WD_MID_MS         600
`define SVW_WD_SHORT_MS       200
`define SVW_CYC_PER_MS        (1000000 / `SVW_CLK_PERIOD_NS)
`define SVW_RELEASE_CYC       (`SVW_RELEASE_MS * `SVW_CYC_PER_MS)
`define SVW_WD_LONG_CYC       (`SVW_WD_LONG_MS * `SVW_CYC_PER_MS)
`define SVW_WD_MID_CYC        (`SVW_WD_MID_MS * `SVW_CYC_PER_MS)
`define SVW_WD_SHORT_CYC      (`SVW_WD_SHORT_MS * `SVW_CYC_PER_MS)
`define SVW_SEL_LONG          2'h0
`define SVW_SEL_MID           2'h1
`define SVW_SEL_SHORT         2'h2
`define SVW_SEL_OFF           2'h3
`define SVW_SEL_DEFAULT       2'h3
`endif

/* svw_host.sv */
// Host model making start and stop conditions on the serial lines
`timescale 1ns/10ps
module svw_host (
   input  wire logic link_clock,
   output logic      scl,
   output logic      sda
);
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   // Start, then a stop only when asked; lines rest high on the pull-ups
   task automatic kick(input bit with_stop);
      @(posedge link_clock) sda <= 1'h0;
      @(posedge link_clock) scl <= 1'h0;
      @(posedge link_clock) sda <= !with_stop;
      @(posedge link_clock) scl <= 1'h1;
      @(posedge link_clock) sda <= 1'h1;
   endtask
endmodule

/* svw_pkg.sv */
// Types for the supervisor watchdog reset block
package svw_pkg;
   typedef struct packed {
      logic period_sel_hi;
      logic period_sel_lo;
   } svw_period_t;
   typedef enum logic [1:0] {
      SVW_IDLE  = 2'h0,
      SVW_ARMED = 2'h1
   } svw_bus_st_t;
endpackage

/* svw_supervisor.sv */
// Supply supervisor reset and watchdog with two-wire restart detection
// Operation
// - Watchdog period: three presets or off
// - Open-drain reset output, polarity parameter
// - Reset asserted while supply below trip
// - Power-up reset, release after continuous delay
// - Supply dip restarts the release delay
// - No start-then-stop within timeout asserts reset
// - Start then stop restarts watchdog count
// - Period from two nonvolatile control bits
// - Write-lock high refuses period changes
// - Data line monitored continuously, never gated
// - Encoding 00 long, 01 mid, 10 short, 11 off
`timescale 1ns/10ps
`include "svw_defines.svh"
module svw_supervisor #(
   parameter bit          RESET_ACTIVE_HIGH = 1'b0,
   parameter int unsigned RELEASE_CYC       = `SVW_RELEASE_CYC,
   parameter int unsigned WD_LONG_CYC       = `SVW_WD_LONG_CYC,
   parameter int unsigned WD_MID_CYC        = `SVW_WD_MID_CYC,
   parameter int unsigned WD_SHORT_CYC      = `SVW_WD_SHORT_CYC
) (
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   input  wire logic                 link_clock,
   input  wire logic                 supply_low,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   input  wire logic                 write_lock,
   input  wire logic                 period_wr,
   input  wire svw_pkg::svw_period_t period_wr_data,
   output logic                      reset_out,
   output logic                      reset_oe,
   output svw_pkg::svw_period_t      period_sel
);
   localparam int CW = 32;

   // Link domain: two-flop sync of bus lines on the link clock
   logic       lk_rst_b_m;
   logic       lk_rst_b;
   logic       scl_m;
   logic       scl_s;
   logic       scl_d;
   logic       sda_m;
   logic       sda_s;
   logic       sda_d;
   logic       sda_chg_tgl_r;
   logic       kick_tgl_r;
   svw_pkg::svw_bus_st_t bus_st_r;

   always_ff @(posedge link_clock or negedge rst_b) begin
      if (!rst_b) begin
         lk_rst_b_m <= 1'b0;
         lk_rst_b   <= 1'b0;
      end else begin
         lk_rst_b_m <= 1'b1;
         lk_rst_b   <= lk_rst_b_m;
      end
   end

   // Line inputs are sampled unconditionally
   always_ff @(posedge link_clock or negedge lk_rst_b) begin
      if (!lk_rst_b) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   logic start_det;
   logic stop_det;
   assign start_det = scl_s && scl_d && sda_d && !sda_s;
   assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

   // Any data-line change toggles sda_chg_tgl_r, which nothing reads; only start-then-stop kicks
   always_ff @(posedge link_clock or negedge lk_rst_b) begin
      if (!lk_rst_b) begin
         bus_st_r      <= svw_pkg::SVW_IDLE;
         kick_tgl_r    <= 1'b0;
         sda_chg_tgl_r <= 1'b0;
      end else begin
         if (sda_s != sda_d) begin
            sda_chg_tgl_r <= ~sda_chg_tgl_r;
         end
         case (bus_st_r)
            svw_pkg::SVW_IDLE: begin
               if (start_det) begin
                  bus_st_r <= svw_pkg::SVW_ARMED;
               end
            end
            svw_pkg::SVW_ARMED: begin
               if (stop_det) begin
                  bus_st_r   <= svw_pkg::SVW_IDLE;
                  kick_tgl_r <= ~kick_tgl_r;
               end
            end
            default: bus_st_r <= svw_pkg::SVW_IDLE;
         endcase
      end
   end

   // Core domain: synchronise inputs and toggles
   logic [2:0] kick_sync;
   logic       low_m;
   logic       low_s;
   logic       lock_m;
   logic       lock_s;
   logic       kick_pulse;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         kick_sync <= 3'h0;
         low_m     <= 1'b1;
         low_s     <= 1'b1;
         lock_m    <= 1'b1;
         lock_s    <= 1'b1;
      end else begin
         kick_sync <= {kick_sync[1:0], kick_tgl_r};
         low_m     <= supply_low;
         low_s     <= low_m;
         lock_m    <= write_lock;
         lock_s    <= lock_m;
      end
   end
   assign kick_pulse = kick_sync[2] ^ kick_sync[1];

   // Period bits kept in retained storage; reset loads the factory value
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         period_sel <= `SVW_SEL_DEFAULT;
      end else if (period_wr && !lock_s) begin
         period_sel <= period_wr_data;
      end
   end

   function automatic logic [CW-1:0] wd_limit(input svw_pkg::svw_period_t sel);
      case (sel)
         `SVW_SEL_LONG:  wd_limit = CW'(WD_LONG_CYC);
         `SVW_SEL_MID:   wd_limit = CW'(WD_MID_CYC);
         `SVW_SEL_SHORT: wd_limit = CW'(WD_SHORT_CYC);
         default:        wd_limit = '0;
      endcase
   endfunction

   logic wd_on;
   assign wd_on = (period_sel != `SVW_SEL_OFF);

   // Release delay: restarts on any dip below trip
   logic [CW-1:0] rel_cnt_r;
   logic          rel_done_r;
   logic          wd_trip_r;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rel_cnt_r  <= '0;
         rel_done_r <= 1'b0;
      end else if (low_s) begin
         rel_cnt_r  <= '0;
         rel_done_r <= 1'b0;
      end else if (wd_trip_r && rel_done_r) begin
         rel_cnt_r  <= '0; // Watchdog trip reruns the release delay
         rel_done_r <= 1'b0;
      end else if (!rel_done_r) begin
         if (rel_cnt_r >= CW'(RELEASE_CYC) - CW'(1)) begin
            rel_done_r <= 1'b1;
         end else begin
            rel_cnt_r <= rel_cnt_r + CW'(1);
         end
      end
   end

   // Watchdog: counts while enabled, cleared by restart or low supply
   logic [CW-1:0] wd_cnt_r;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wd_cnt_r  <= '0;
         wd_trip_r <= 1'b0;
      end else if (low_s || !rel_done_r || !wd_on || kick_pulse) begin
         wd_cnt_r  <= '0;
         wd_trip_r <= 1'b0;
      end else if (wd_cnt_r >= wd_limit(period_sel) - CW'(1)) begin
         wd_cnt_r  <= '0;
         wd_trip_r <= 1'b1;
      end else begin
         wd_cnt_r <= wd_cnt_r + CW'(1);
      end
   end

   // Watchdog trip holds reset and reruns the release delay
   logic rst_act;
   assign rst_act = low_s || !rel_done_r || wd_trip_r;

   // Open-drain drive; active-high variant drives low when inactive
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reset_out <= 1'b0;
         reset_oe  <= ~RESET_ACTIVE_HIGH;
      end else begin
         reset_out <= 1'b0;
         reset_oe  <= RESET_ACTIVE_HIGH ? ~rst_act : rst_act;
      end
   end
endmodule

/* svw_supervisor_properties.sv */
// Checker for the supervisor watchdog reset block
`timescale 1ns/10ps
module svw_supervisor_chk #(
   parameter int RELEASE_CYC  = 50,
   parameter int WD_LONG_CYC  = 3000,
   parameter int WD_MID_CYC   = 2000,
   parameter int WD_SHORT_CYC = 1000
) (
   input wire logic                 clock,
   input wire logic                 rst_b,
   input wire logic                 link_clock,
   input wire logic                 supply_low,
   input wire logic                 scl_in,
   input wire logic                 sda_in,
   input wire logic                 write_lock,
   input wire logic                 period_wr,
   input wire svw_pkg::svw_period_t period_wr_data,
   input wire logic                 reset_out,
   input wire logic                 reset_oe,
   input wire svw_pkg::svw_period_t period_sel
);
   int hi_n;
   int up_n;
   int lim;
   // Cycles of good supply and cycles since release
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hi_n <= 0;
         up_n <= 0;
      end else begin
         hi_n <= supply_low ? 0 : hi_n + 1;
         up_n <= reset_oe ? 0 : up_n + 1;
      end
   end
   assign lim = (period_sel == 2'h0) ? WD_LONG_CYC :
                (period_sel == 2'h1) ? WD_MID_CYC : WD_SHORT_CYC;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_pin_zero: assert property (reset_out == 1'h0)
      else $error("reset pin data not low");
   a_low_asserts: assert property (supply_low [*4] |-> reset_oe)
      else $error("reset not asserted on low supply");
   a_release_wait: assert property ($fell(reset_oe) |-> hi_n >= RELEASE_CYC)
      else $error("reset released too early");
   a_lock_hold: assert property (write_lock [*3] |=> $stable(period_sel))
      else $error("period changed while locked");
   a_write_takes: assert property (!write_lock [*3] ##0 period_wr |=>
      period_sel == $past(period_wr_data)) else $error("period write lost");
   a_wd_early: assert property ($rose(reset_oe) && hi_n > 8 |-> up_n >= lim - 2)
      else $error("watchdog tripped early");
   a_off_quiet: assert property ($rose(reset_oe) && period_sel == 2'h3 |-> hi_n < 6)
      else $error("watchdog tripped while off");
   a_sel_dflt: assert property ($rose(rst_b) |-> period_sel == 2'h3)
      else $error("period not off after reset");
   cover property ($fell(reset_oe));
   cover property ($rose(reset_oe) && hi_n > 8);
   cover property (write_lock && period_wr);
endmodule
bind svw_supervisor svw_supervisor_chk #(.RELEASE_CYC(RELEASE_CYC), .WD_LONG_CYC(WD_LONG_CYC),
   .WD_MID_CYC(WD_MID_CYC), .WD_SHORT_CYC(WD_SHORT_CYC)) u_chk (.*);

/* svw_supervisor_tb_top.sv */
// Testbench for the supervisor watchdog reset block
`timescale 1ns/10ps
module svw_supervisor_tb_top;
   typedef struct {logic [1:0] code; int lo; int hi; int rlo;} svw_row_t;
   logic clock, rst_b, link_clock, supply_low, scl, sda, write_lock, period_wr;
   logic reset_out, reset_oe;
   svw_pkg::svw_period_t wr_data, period_sel;
   int fails, compares, cyc, n;
   svw_row_t rows[4] = '{'{2'h3, 9000, 9000, 0}, '{2'h2, 990, 1200, 48},
                         '{2'h1, 1990, 2200, 48}, '{2'h0, 2990, 3200, 48}};
   localparam int unsigned REL_N   = 50;
   localparam int unsigned LONG_N  = 3000;
   localparam int unsigned MID_N   = 2000;
   localparam int unsigned SHORT_N = 1000;
   svw_supervisor #(.RELEASE_CYC(REL_N), .WD_LONG_CYC(LONG_N), .WD_MID_CYC(MID_N),
      .WD_SHORT_CYC(SHORT_N)) DUT (.clock(clock), .rst_b(rst_b), .link_clock(link_clock),
      .supply_low(supply_low), .scl_in(scl), .sda_in(sda), .write_lock(write_lock),
      .period_wr(period_wr), .period_wr_data(wr_data), .reset_out(reset_out),
      .reset_oe(reset_oe), .period_sel(period_sel));
   svw_host host (.link_clock(link_clock), .scl(scl), .sda(sda));
   always #2 clock = ~clock;
   initial begin
      link_clock = 1'h0;
      #13;
      forever #80 link_clock = ~link_clock;
   end
   task automatic results;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (exp !== got) begin
         $display("ERROR %s expected %0h seen %0h", nm, exp, got);
         fails++;
      end
   endtask
   task automatic in_rng(input string nm, input int lo, input int hi, input int v);
      compares++;
      if (v < lo || v > hi) begin
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, v);
         fails++;
      end
   endtask
   // Cycles until the pin enable reaches lvl, capped
   task automatic wait_oe(input logic lvl, output int k);
      k = 0;
      while (reset_oe !== lvl && k < 9000) begin
         @(negedge clock);
         k++;
      end
   endtask
   task automatic wr(input logic [1:0] code, input logic [1:0] exp);
      @(posedge clock);
      period_wr <= 1'h1;
      wr_data   <= code;
      @(posedge clock);
      period_wr <= 1'h0;
      @(negedge clock);
      chk("period_sel", exp, period_sel);
   endtask
   initial begin
      clock = 1'h0;
      rst_b = 1'h0;
      supply_low = 1'h0;
      write_lock = 1'h0;
      period_wr = 1'h0;
      wr_data = 2'h3;
      repeat (12) @(posedge clock);
      chk("oe_in_reset", 1, reset_oe);
      chk("sel_dflt", 3, period_sel);
      rst_b <= 1'h1;
      wait_oe(1'h0, n);
      in_rng("por_delay", 48, 60, n);
      foreach (rows[i]) begin
         wr(rows[i].code, rows[i].code);
         repeat (200) @(posedge clock);
         host.kick(1'h1);
         wait_oe(1'h1, n);
         in_rng("wd_trip", rows[i].lo, rows[i].hi, n);
         wait_oe(1'h0, n);
         in_rng("wd_release", rows[i].rlo, rows[i].rlo + 12, n);
      end
      wr(2'h2, 2'h2);
      repeat (200) @(posedge clock);
      host.kick(1'h0);
      wait_oe(1'h1, n);
      in_rng("no_stop", 0, 800, n);
      wait_oe(1'h0, n);
      write_lock <= 1'h1;
      repeat (4) @(posedge clock);
      wr(2'h0, 2'h2);
      write_lock <= 1'h0;
      repeat (4) @(posedge clock);
      wr(2'h3, 2'h3);
      supply_low <= 1'h1;
      repeat (4) @(negedge clock);
      chk("low_assert", 1, reset_oe);
      @(posedge clock) supply_low <= 1'h0;
      repeat (30) @(posedge clock);
      supply_low <= 1'h1;
      @(negedge clock);
      chk("dip_hold", 1, reset_oe);
      @(posedge clock) supply_low <= 1'h0;
      wait_oe(1'h0, n);
      in_rng("brown_rel", 48, 60, n);
      results();
   end
endmodule
